// [rtl/asf_map.svh]
// Register indices, flag bit positions and reset values of the ALU flag block
`ifndef ASF_MAP_SVH
`define ASF_MAP_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define ASF_IDX_FLAG      8'h04
`define ASF_IDX_PROD_LOW  8'h18
`define ASF_IDX_PROD_HIGH 8'h19

// ****************************************
// Flag register fields
// ****************************************
`define ASF_BIT_CARRY     0
`define ASF_BIT_NIBBLE    1
`define ASF_BIT_ZERO      2
`define ASF_BIT_RANGE     3
`define ASF_PTR0_LSB      4
`define ASF_PTR1_LSB      6

// ****************************************
// Reset values and bus answers
// ****************************************
`define ASF_FLAG_RST      8'h00
`define ASF_RESP_OKAY     1'b0
`define ASF_READ_WAITS    1

`endif

// [rtl/asf_pkg.sv]
// Types shared by the ALU flag block
package asf_pkg;

    // ****************************************
    // Operations issued by the execution logic
    // ****************************************
    typedef enum logic [4:0] {
        ASF_ADD, ASF_SUB, ASF_AND, ASF_IOR, ASF_XOR,
        ASF_CLR, ASF_BCLR, ASF_BSET, ASF_SWAP, ASF_MOVA,
        ASF_RRC, ASF_RLC, ASF_INC, ASF_DEC, ASF_MUL
    } asf_op_t;

    // ****************************************
    // Operand source select
    // ****************************************
    typedef enum logic [1:0] {
        ASF_SRC_ACC, ASF_SRC_FILE, ASF_SRC_LIT
    } asf_src_t;

    // ****************************************
    // Bus slave states
    // ****************************************
    typedef enum logic [1:0] {
        BUS_IDLE, BUS_WRITE, BUS_READ, BUS_RDONE
    } asf_bus_t;

endpackage

// [rtl/asf_adder8.sv]
// Eight-bit adder with carry, nibble carry and signed range flags
`timescale 1ns/1ps

module asf_adder8 (
    input  wire logic [7:0] x,
    input  wire logic [7:0] y,
    input  wire logic       cin,
    output logic      [7:0] sum,
    output logic            carryOut,
    output logic            nibbleCarry,
    output logic            rangeOut
);

    logic [8:0] full;
    logic [4:0] low;

    // ****************************************
    // Sum and carries
    // ****************************************
    assign full        = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    assign low         = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    assign sum         = full[7:0];
    assign carryOut    = full[8];
    assign nibbleCarry = low[4];
    // Sign change with equal operand signs
    assign rangeOut    = (x[7] == y[7]) && (full[7] != x[7]);

endmodule // asf_adder8

// [rtl/asf_alu_flags.sv]
// ALU operand select, status flag logic, product registers and AHB-Lite access
//
// How it works
// - Flag register as destination: flag logic sets the flag bits the op affects, the rest of the low nibble keeps; ops affecting no flag write all bits
// - Clear of flag register zeroes upper nibble, sets zero, keeps others
// - Bit clear, bit set, swap and move change flags only when the flag register is their destination
// - In subtraction carry and nibble carry mean no-borrow, inverted sense
// - Signed range flag set when result leaves -128 to +127
// - Single-operand ops take accumulator or named file register
// - Two-operand ops use accumulator plus file register or literal
// - Flag register also holds both pointer mode fields
// - Multiply low byte to index 18h, high byte to 19h
// - Product registers have no reset; other resets keep them
// - Add ops set nibble carry on carry out of bit three
// - Subtraction adds two's complement; flags come from that sum
// - Rotate through carry loads carry with the bit shifted out
// - Flag register sits at index 04h with no bank dependence
`timescale 1ns/1ps
`include "asf_map.svh"

module asf_alu_flags (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [31:0]       hrdata,
    // Execution logic
    input  wire logic              opValid,
    input  wire asf_pkg::asf_op_t  opCode,
    input  wire asf_pkg::asf_src_t opSrc,
    input  wire logic [7:0]        accData,
    input  wire logic [7:0]        fileData,
    input  wire logic [7:0]        literal,
    input  wire logic [2:0]        bitSel,
    input  wire logic [7:0]        destAddr,
    output logic      [7:0]        result,
    output logic                   resultValid,
    output logic      [7:0]        aluFlags,
    output logic      [1:0]        pointer0Mode,
    output logic      [1:0]        pointer1Mode,
    output logic      [7:0]        productLow,
    output logic      [7:0]        productHigh
);
    import asf_pkg::*;

    // ****************************************
    // Decode functions
    // ****************************************
    function automatic logic [3:0] flagMask(input asf_op_t op);
        unique case (op)
            ASF_ADD, ASF_SUB, ASF_INC, ASF_DEC: flagMask = 4'hF;
            ASF_AND, ASF_IOR, ASF_XOR, ASF_CLR: flagMask = 4'h4;
            ASF_RRC, ASF_RLC:                   flagMask = 4'h1;
            ASF_BCLR, ASF_BSET, ASF_SWAP, ASF_MOVA, ASF_MUL: flagMask = 4'h0;
            default:                            flagMask = 4'h0;
        endcase
    endfunction

    function automatic logic isMapped(input logic [7:0] idx);
        isMapped = (idx == `ASF_IDX_FLAG) || (idx == `ASF_IDX_PROD_LOW) ||
                   (idx == `ASF_IDX_PROD_HIGH);
    endfunction

    // ****************************************
    // Signals
    // ****************************************
    logic [7:0]  flagReg_r;
    logic [7:0]  flag_nxt;
    logic [7:0]  prodLow_r;
    logic [7:0]  prodHigh_r;
    logic [7:0]  result_r;
    logic        resultValid_r;
    logic [31:0] hrdata_r;
    asf_bus_t    busState_r;
    logic [7:0]  busIdx_r;
    logic        busOk_r;
    logic [7:0]  opnd;
    logic [7:0]  opB;
    logic [7:0]  addX;
    logic [7:0]  addY;
    logic        addCin;
    logic [7:0]  sum;
    logic        sumCarry;
    logic        sumNibble;
    logic        sumRange;
    logic [7:0]  res;
    logic [3:0]  calcFlags;
    logic [3:0]  mask;
    logic [7:0]  bitMask;
    logic [15:0] prod;
    logic        destFlag;
    logic        accept;
    logic        busWrFlag;
    logic        busWrLow;
    logic        busWrHigh;

    // ****************************************
    // Operand selection
    // ****************************************
    // single operand source
    assign opnd = (opSrc == ASF_SRC_ACC) ? accData : fileData;
    assign opB  = (opSrc == ASF_SRC_LIT) ? literal : fileData;
    assign bitMask = 8'h01 << bitSel;
    assign prod = {8'h00, accData} * {8'h00, opB};
    assign destFlag = (destAddr == `ASF_IDX_FLAG);
    assign mask = flagMask(opCode);

    // ****************************************
    // Adder inputs
    // ****************************************
    always_comb begin
        addX   = opB;
        addY   = accData;
        addCin = 1'b0;
        unique case (opCode)
            ASF_SUB: begin
                addY   = ~accData;
                addCin = 1'b1;
            end
            ASF_INC: begin
                addX   = opnd;
                addY   = 8'h00;
                addCin = 1'b1;
            end
            ASF_DEC: begin
                addX   = opnd;
                addY   = 8'hFF;
            end
            default: begin
                addCin = 1'b0;
            end
        endcase
    end

    asf_adder8 uAdder (
        .x           (addX),
        .y           (addY),
        .cin         (addCin),
        .sum         (sum),
        .carryOut    (sumCarry),
        .nibbleCarry (sumNibble),
        .rangeOut    (sumRange)
    );

    // ****************************************
    // Result and computed flags
    // ****************************************
    always_comb begin
        res       = sum;
        calcFlags = 4'h0;
        calcFlags[`ASF_BIT_CARRY]  = sumCarry;
        calcFlags[`ASF_BIT_NIBBLE] = sumNibble;
        calcFlags[`ASF_BIT_RANGE]  = sumRange;
        unique case (opCode)
            ASF_AND:  res = accData & opB;
            ASF_IOR:  res = accData | opB;
            ASF_XOR:  res = accData ^ opB;
            ASF_CLR:  res = 8'h00;
            ASF_BCLR: res = opnd & ~bitMask;
            ASF_BSET: res = opnd | bitMask;
            ASF_SWAP: res = {opnd[3:0], opnd[7:4]};
            ASF_MOVA: res = accData;
            ASF_MUL:  res = prod[7:0];
            ASF_RRC: begin
                res = {flagReg_r[`ASF_BIT_CARRY], opnd[7:1]};
                calcFlags[`ASF_BIT_CARRY] = opnd[0];
            end
            ASF_RLC: begin
                res = {opnd[6:0], flagReg_r[`ASF_BIT_CARRY]};
                calcFlags[`ASF_BIT_CARRY] = opnd[7];
            end
            default: res = sum;
        endcase
        calcFlags[`ASF_BIT_ZERO] = (res == 8'h00);
    end

    // ****************************************
    // Flag register next value
    // ****************************************
    always_comb begin
        flag_nxt = busWrFlag ? hwdata[7:0] : flagReg_r;
        if (opValid) begin
            if (destFlag) begin
                flag_nxt = res;
                if (|mask) begin
                    flag_nxt[3:0] = flagReg_r[3:0];
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (mask[i]) begin
                    flag_nxt[i] = calcFlags[i];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flagReg_r <= `ASF_FLAG_RST;
        end else begin
            flagReg_r <= flag_nxt;
        end
    end

    // ****************************************
    // Product registers
    // ****************************************
    // no reset on product
    always_ff @(posedge clk) begin
        if (opValid && opCode == ASF_MUL) begin
            prodLow_r  <= prod[7:0];
            prodHigh_r <= prod[15:8];
        end else begin
            if (busWrLow) begin
                prodLow_r <= hwdata[7:0];
            end
            if (busWrHigh) begin
                prodHigh_r <= hwdata[7:0];
            end
        end
    end

    // ****************************************
    // Result output
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_r      <= 8'h00;
            resultValid_r <= 1'b0;
        end else begin
            resultValid_r <= opValid;
            if (opValid) begin
                result_r <= res;
            end
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    assign accept    = hsel && htrans[1] && hready;
    assign busWrFlag = (busState_r == BUS_WRITE) && busOk_r && (busIdx_r == `ASF_IDX_FLAG);
    assign busWrLow  = (busState_r == BUS_WRITE) && busOk_r &&
                       (busIdx_r == `ASF_IDX_PROD_LOW);
    assign busWrHigh = (busState_r == BUS_WRITE) && busOk_r &&
                       (busIdx_r == `ASF_IDX_PROD_HIGH);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busState_r <= BUS_IDLE;
            busIdx_r   <= 8'h00;
            busOk_r    <= 1'b0;
        end else begin
            unique case (busState_r)
                BUS_READ: busState_r <= BUS_RDONE;
                BUS_IDLE, BUS_WRITE, BUS_RDONE: begin
                    if (accept) begin
                        busState_r <= hwrite ? BUS_WRITE : BUS_READ;
                    end else begin
                        busState_r <= BUS_IDLE;
                    end
                end
            endcase
            if (accept) begin
                busIdx_r <= haddr[9:2];
                busOk_r  <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00) &&
                            isMapped(haddr[9:2]);
            end
        end
    end

    // Read data captured in the wait cycle, after any prior write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_r <= 32'h00000000;
        end else if (busState_r == BUS_READ) begin
            hrdata_r <= 32'h00000000;
            if (busOk_r && busIdx_r == `ASF_IDX_FLAG) begin
                hrdata_r <= {24'h000000, flagReg_r};
            end else if (busOk_r && busIdx_r == `ASF_IDX_PROD_LOW) begin
                hrdata_r <= {24'h000000, prodLow_r};
            end else if (busOk_r && busIdx_r == `ASF_IDX_PROD_HIGH) begin
                hrdata_r <= {24'h000000, prodHigh_r};
            end
        end
    end

    assign hreadyout    = (busState_r != BUS_READ);
    assign hresp        = `ASF_RESP_OKAY;
    assign hrdata       = hrdata_r;
    assign result       = result_r;
    assign resultValid  = resultValid_r;
    assign aluFlags     = flagReg_r;
    assign pointer0Mode = flagReg_r[`ASF_PTR0_LSB +: 2];
    assign pointer1Mode = flagReg_r[`ASF_PTR1_LSB +: 2];
    assign productLow   = prodLow_r;
    assign productHigh  = prodHigh_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [9:0] sgnSum;
    logic       rangeRef;
    logic       nibbleRef;
    assign sgnSum    = {{2{opB[7]}}, opB} + {{2{accData[7]}}, accData};
    assign rangeRef  = ($signed(sgnSum) > 10'sd127) || ($signed(sgnSum) < -10'sd128);
    assign nibbleRef = ({1'b0, opB[3:0]} + {1'b0, accData[3:0]}) > 5'h0F;

    flag_dest_a: assert property (
        opValid && destFlag && mask[0] |=> flagReg_r[0] == $past(calcFlags[0]))
        else $error("carry not set by flag logic on flag destination");

    clear_file_a: assert property (
        opValid && opCode == ASF_CLR && destFlag && !busWrFlag |=>
        flagReg_r[7:4] == 4'h0 && flagReg_r[2] && flagReg_r[3] == $past(flagReg_r[3]) &&
        flagReg_r[1:0] == $past(flagReg_r[1:0]))
        else $error("clear of flag register gave wrong pattern");

    quiet_ops_a: assert property (
        opValid && !destFlag && !busWrFlag &&
        (opCode inside {ASF_BCLR, ASF_BSET, ASF_SWAP, ASF_MOVA}) |=>
        $stable(flagReg_r))
        else $error("flag changed by a quiet operation");

    borrow_a: assert property (
        opValid && opCode == ASF_SUB |=> flagReg_r[0] == ($past(opB) >= $past(accData)))
        else $error("borrow sense wrong in subtraction");

    range_flag_a: assert property (
        opValid && opCode == ASF_ADD |=> flagReg_r[3] == $past(rangeRef))
        else $error("signed range flag wrong");

    literal_op_a: assert property (
        opValid && opCode == ASF_AND && opSrc == ASF_SRC_LIT ##1 resultValid |->
        result == ($past(accData) & $past(literal)))
        else $error("literal operand not used");

    product_a: assert property (
        opValid && opCode == ASF_MUL |=>
        {productHigh, productLow} == $past(accData) * $past(opB))
        else $error("product bytes misplaced");

    nibble_a: assert property (
        opValid && opCode == ASF_ADD |=> flagReg_r[1] == $past(nibbleRef))
        else $error("nibble carry wrong on add");

    rotate_a: assert property (
        opValid && opCode == ASF_RRC |=> flagReg_r[0] == $past(opnd[0]))
        else $error("rotate right did not load carry");

    zero_flag_a: assert property (
        opValid && opCode == ASF_XOR |=> flagReg_r[2] == (result == 8'h00))
        else $error("zero flag disagrees with result");

    bus_flag_a: assert property (
        accept && hwrite && haddr == {22'h0, `ASF_IDX_FLAG, 2'b00} ##1 !opValid |=>
        flagReg_r == $past(hwdata[7:0]))
        else $error("bus write to flag register lost");

    read_wait_a: assert property (
        accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not exactly one cycle");

    add_dest_c: cover property (opValid && opCode == ASF_ADD && destFlag);
    clear_c:    cover property (opValid && opCode == ASF_CLR && destFlag);
    mul_read_c: cover property (opValid && opCode == ASF_MUL ##1 accept && !hwrite);

endmodule // asf_alu_flags

// [tb/asf_exec_model.sv]
// Behavioural model of the execution logic that feeds the ALU flag block
`timescale 1ns/1ps

module asf_exec_model (
    input  wire logic              clk,
    output logic                   opValid,
    output asf_pkg::asf_op_t       opCode,
    output asf_pkg::asf_src_t      opSrc,
    output logic [7:0]             accData,
    output logic [7:0]             fileData,
    output logic [7:0]             literal,
    output logic [2:0]             bitSel,
    output logic [7:0]             destAddr
);
    import asf_pkg::*;

    initial begin
        opValid  = 1'b0;
        opCode   = ASF_ADD;
        opSrc    = ASF_SRC_ACC;
        accData  = 8'h00;
        fileData = 8'h00;
        literal  = 8'h00;
        bitSel   = 3'h0;
        destAddr = 8'h00;
    end

    // ****************************************
    // One operation, after gap idle cycles
    // ****************************************
    task automatic issue(input asf_op_t op, input asf_src_t src, input logic [7:0] acc,
                         input logic [7:0] fil, input logic [7:0] lit, input logic [2:0] bs,
                         input logic [7:0] dst, input int gap);
        repeat (gap) @(posedge clk);
        opValid  <= 1'b1;
        opCode   <= op;
        opSrc    <= src;
        accData  <= acc;
        fileData <= fil;
        literal  <= lit;
        bitSel   <= bs;
        destAddr <= dst;
        @(posedge clk);
        opValid  <= 1'b0;
        // Released operand lines do not keep their last value
        accData  <= ~acc;
        fileData <= ~fil;
        literal  <= ~lit;
        bitSel   <= ~bs;
    endtask
endmodule // asf_exec_model

// [tb/tb.sv]
// Self-checking bench of the ALU flag block
`timescale 1ns/1ps
`include "asf_map.svh"

module tb;
    import asf_pkg::*;
    typedef struct packed {
        asf_op_t op; asf_src_t src; logic [7:0] acc; logic [7:0] fil;
        logic [7:0] lit; logic [2:0] bs; logic [7:0] res; logic [3:0] flg;
    } asf_row_t;

    logic        clk = 1'b0;
    logic        sysRst = 1'b1;
    logic        hsel, hwrite, hreadyout, hresp, opValid, resultValid;
    logic [31:0] haddr, hwdata, hrdata, rdData;
    logic [1:0]  htrans, pointer0Mode, pointer1Mode;
    logic [2:0]  hsize, bitSel;
    logic [7:0]  accData, fileData, literal, destAddr, result, aluFlags;
    logic [7:0]  productLow, productHigh, resSeen, flgSeen;
    logic        vldSeen;
    asf_op_t     opCode;
    asf_src_t    opSrc;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    asf_row_t rows [18] = '{
        '{ASF_ADD,  ASF_SRC_LIT,  8'h7F, 8'h00, 8'h01, 3'h0, 8'h80, 4'hA},
        '{ASF_ADD,  ASF_SRC_FILE, 8'hFF, 8'h01, 8'h00, 3'h0, 8'h00, 4'h7},
        '{ASF_SUB,  ASF_SRC_FILE, 8'h01, 8'h03, 8'h00, 3'h0, 8'h02, 4'h3},
        '{ASF_SUB,  ASF_SRC_LIT,  8'h05, 8'h00, 8'h03, 3'h0, 8'hFE, 4'h0},
        '{ASF_SUB,  ASF_SRC_LIT,  8'h01, 8'h00, 8'h80, 3'h0, 8'h7F, 4'h9},
        '{ASF_AND,  ASF_SRC_LIT,  8'h0F, 8'h00, 8'hF0, 3'h0, 8'h00, 4'hD},
        '{ASF_IOR,  ASF_SRC_LIT,  8'h0F, 8'h00, 8'h30, 3'h0, 8'h3F, 4'h9},
        '{ASF_XOR,  ASF_SRC_FILE, 8'hAA, 8'hAA, 8'h00, 3'h0, 8'h00, 4'hD},
        '{ASF_BSET, ASF_SRC_FILE, 8'h00, 8'h00, 8'h00, 3'h7, 8'h80, 4'hD},
        '{ASF_BCLR, ASF_SRC_FILE, 8'h00, 8'hFF, 8'h00, 3'h0, 8'hFE, 4'hD},
        '{ASF_SWAP, ASF_SRC_FILE, 8'h00, 8'hA5, 8'h00, 3'h0, 8'h5A, 4'hD},
        '{ASF_MOVA, ASF_SRC_ACC,  8'h3C, 8'h00, 8'h00, 3'h0, 8'h3C, 4'hD},
        '{ASF_RRC,  ASF_SRC_FILE, 8'h00, 8'h02, 8'h00, 3'h0, 8'h81, 4'hC},
        '{ASF_RLC,  ASF_SRC_ACC,  8'h81, 8'h00, 8'h00, 3'h0, 8'h02, 4'hD},
        '{ASF_INC,  ASF_SRC_FILE, 8'h00, 8'hFF, 8'h00, 3'h0, 8'h00, 4'h7},
        '{ASF_DEC,  ASF_SRC_ACC,  8'h80, 8'h00, 8'h00, 3'h0, 8'h7F, 4'h9},
        '{ASF_CLR,  ASF_SRC_FILE, 8'h00, 8'h55, 8'h00, 3'h0, 8'h00, 4'hD},
        '{ASF_MUL,  ASF_SRC_FILE, 8'hC8, 8'hC8, 8'h00, 3'h0, 8'h40, 4'hD}
    };

    asf_alu_flags asf_alu_flags_inst (
        .clk(clk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .opValid(opValid),
        .opCode(opCode), .opSrc(opSrc), .accData(accData), .fileData(fileData),
        .literal(literal), .bitSel(bitSel), .destAddr(destAddr), .result(result),
        .resultValid(resultValid), .aluFlags(aluFlags), .pointer0Mode(pointer0Mode),
        .pointer1Mode(pointer1Mode), .productLow(productLow), .productHigh(productHigh)
    );

    asf_exec_model asf_exec_model_inst (
        .clk(clk), .opValid(opValid), .opCode(opCode), .opSrc(opSrc), .accData(accData),
        .fileData(fileData), .literal(literal), .bitSel(bitSel), .destAddr(destAddr)
    );

    always #12.5 clk = ~clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            error_cnt++;
            finish_test;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_ready;
        logic rdy;
        do begin
            @(negedge clk);
            rdy = hreadyout;
            rdData = hrdata;
            @(posedge clk);
        end while (rdy !== 1'b1);
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        wait_ready;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_ready;
    endtask

    task automatic run_op(input asf_row_t r, input logic [7:0] dst, input int gap);
        asf_exec_model_inst.issue(r.op, r.src, r.acc, r.fil, r.lit, r.bs, dst, gap);
        @(negedge clk);
        resSeen = result;
        flgSeen = aluFlags;
        vldSeen = resultValid;
        @(posedge clk);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 18; i++) begin
            run_op(rows[i], 8'h20, i % 3);
            check("result", resSeen, rows[i].res);
            check("resultValid", vldSeen, 1'b1);
            check("flags", flgSeen, {4'h0, rows[i].flg});
        end
        check("productHigh", productHigh, 8'h9C);
        $display("test operation table done");
        sysRst <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check("flagsInReset", aluFlags, 8'h00);
        check("readyInReset", hreadyout, 1'b1);
        check("resultInReset", result, 8'h00);
        check("productLowKept", productLow, 8'h40);
        check("productHighKept", productHigh, 8'h9C);
        @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        $display("test reset done");
        bus(1'b0, `ASF_IDX_PROD_LOW, 8'h00);
        check("busProductLow", rdData, 32'h40);
        bus(1'b0, `ASF_IDX_PROD_HIGH, 8'h00);
        check("busProductHigh", rdData, 32'h9C);
        bus(1'b1, `ASF_IDX_FLAG, 8'hA5);
        bus(1'b0, `ASF_IDX_FLAG, 8'h00);
        check("busFlags", rdData, 32'hA5);
        check("pointer0Mode", pointer0Mode, 2'b10);
        check("pointer1Mode", pointer1Mode, 2'b10);
        bus(1'b1, 8'h20, 8'hFF);
        bus(1'b0, 8'h20, 8'h00);
        check("busUnmapped", rdData, 32'h0);
        check("hresp", hresp, 1'b0);
        $display("test register bus done");
        bus(1'b1, `ASF_IDX_FLAG, 8'h0B);
        run_op('{ASF_CLR, ASF_SRC_FILE, 8'h00, 8'h00, 8'h00, 3'h0, 8'h00, 4'h0}, 8'h04, 0);
        check("clearFlagReg", flgSeen, 8'h0F);
        run_op('{ASF_ADD, ASF_SRC_LIT, 8'h10, 8'h00, 8'h20, 3'h0, 8'h00, 4'h0}, 8'h04, 1);
        check("addToFlagReg", flgSeen, 8'h30);
        run_op('{ASF_BSET, ASF_SRC_FILE, 8'h00, 8'h30, 8'h00, 3'h7, 8'h00, 4'h0}, 8'h04, 0);
        check("bitSetFlagReg", flgSeen, 8'hB0);
        $display("test flag register destination done");
        finish_test;
    end
endmodule // tb
